// ==== rtl/irqc_pkg.sv ====
// shared constants of the interrupt priority controller
package irqc_pkg;
	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int          ADDR_W            = 18;
	localparam logic [15:0] IDX_SYSTEM_CONTROL = 16'hFFF2;
	localparam logic [15:0] IDX_SENSE_CONTROL  = 16'hFFF4;
	localparam logic [15:0] IDX_ENABLE_MASK    = 16'hFFF5;
	localparam logic [15:0] IDX_PENDING_FLAGS  = 16'hFFF6;
	localparam logic [15:0] IDX_PRIORITY_A     = 16'hFFF8;
	localparam logic [15:0] IDX_PRIORITY_B     = 16'hFFF9;

	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h0B;
	localparam logic [7:0] RST_ZERO           = 8'h00;
	localparam int         BIT_USER_SELECT    = 3;
	localparam int         BIT_NMI_EDGE       = 2;

	// ------------------------------------------------------------
	// source counts and vector numbers
	// ------------------------------------------------------------
	localparam int         N_EXT      = 6;
	localparam int         N_INT      = 30;
	localparam int         N_SRC      = N_EXT + N_INT;
	localparam logic [7:0] VEC_NMI    = 8'h07;
	localparam logic [7:0] VEC_TRAP   = 8'h08;
	localparam int         VEC_IRQ0   = 12;
	localparam int         VEC_WDT    = 20;
	localparam int         VEC_TPU    = 24;
	localparam int         VEC_DMA    = 44;
	localparam int         VEC_SCI    = 52;
	localparam int         VEC_ADC    = 60;
	// internal source index groups
	localparam int         SRC_TPU    = 2;
	localparam int         SRC_DMA    = 17;
	localparam int         SRC_SCI    = 21;
	localparam int         SRC_ADC    = 29;

	// exception sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_PUSH  = 2'b01,
		ST_MASK  = 2'b10,
		ST_FETCH = 2'b11
	} exc_state_t;
endpackage

// ==== rtl/interrupt_priority_controller.sv ====
// interrupt priority controller with apb register slave
`timescale 1ns/1ns
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module interrupt_priority_controller
	import irqc_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n,
	input  wire logic              i_hw_standby,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// request sources
	input  wire logic              i_nmi,
	input  wire logic [N_EXT-1:0]  i_irq_n,
	input  wire logic [N_INT-1:0]  i_int_req,
	// cpu side
	input  wire logic              i_ccr_i,
	input  wire logic              i_ccr_ui,
	input  wire logic              i_insn_done,
	input  wire logic              i_trap_exec,
	input  wire logic [1:0]        i_trap_num,
	input  wire logic [23:0]       i_acc_addr,
	input  wire logic              i_acc_wide,
	// exception outputs
	output logic                   o_busy,
	output logic                   o_push_req,
	output logic                   o_set_i,
	output logic                   o_set_ui,
	output logic                   o_vec_valid,
	output logic      [7:0]        o_vec_num,
	output logic      [15:0]       o_vec_addr,
	output logic      [23:0]       o_acc_addr
);
	// ------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------
	// level bit of a source: index 0..5 external, 6..35 internal
	function automatic logic prio_of(input int idx, input logic [7:0] pa,
	                                 input logic [7:0] pb);
		int k;
		k = idx - N_EXT;
		if (idx == 0) prio_of = pa[7];
		else if (idx == 1) prio_of = pa[6];
		else if (idx < 4) prio_of = pa[5];
		else if (idx < N_EXT) prio_of = pa[4];
		else if (k < SRC_TPU) prio_of = pa[3];
		else if (k < SRC_DMA) prio_of = (k < 5) ? pa[2] : (k < 8) ? pa[1] :
		                                (k < 11) ? pa[0] : (k < 14) ? pb[7] : pb[6];
		else if (k < SRC_SCI) prio_of = (k < 19) ? pb[5] : pb[4];
		else if (k < SRC_ADC) prio_of = (k < 25) ? pb[3] : pb[2];
		else prio_of = pb[1];
	endfunction

	// vector number of a source
	function automatic logic [7:0] vec_of(input int idx);
		int k;
		int v;
		k = idx - N_EXT;
		if (idx < N_EXT) v = VEC_IRQ0 + idx;
		else if (k < SRC_TPU) v = VEC_WDT + k;
		else if (k < SRC_DMA) v = VEC_TPU + 4 * ((k - SRC_TPU) / 3) + (k - SRC_TPU) % 3;
		else if (k < SRC_SCI) v = VEC_DMA + (k - SRC_DMA);
		else if (k < SRC_ADC) v = VEC_SCI + (k - SRC_SCI);
		else v = VEC_ADC;
		vec_of = v[7:0];
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0]       sysctl_r;
	logic [7:0]       sense_r;
	logic [7:0]       enable_r;
	logic [5:0]       pend_r;
	logic [7:0]       prio_a_r;
	logic [7:0]       prio_b_r;
	logic             nmi_prev_r;
	logic [5:0]       irq_prev_n_r;
	logic             nmi_pend_r;
	logic             armed_r;
	logic             ack_nmi_r;
	logic             ack_hi_r;
	logic [7:0]       vec_sel_r;
	logic             trap_r;
	exc_state_t       state_r;
	exc_state_t       state_nxt;

	logic             ue;
	logic             wr_cyc;
	logic             mapped;
	logic [5:0]       irq_set;
	logic             nmi_edge;
	logic [N_SRC-1:0] req;
	logic [N_SRC-1:0] lvl;
	logic             mask_all;
	logic             found1;
	logic             found0;
	int               sel1;
	int               sel0;
	logic             take_int;
	logic             take_trap;
	logic [7:0]       vec_take;

	assign ue     = sysctl_r[BIT_USER_SELECT];
	assign wr_cyc = i_psel & i_penable & o_pready & i_pwrite;
	assign mapped = hit(i_paddr, IDX_SYSTEM_CONTROL) | hit(i_paddr, IDX_SENSE_CONTROL) |
	                hit(i_paddr, IDX_ENABLE_MASK) | hit(i_paddr, IDX_PENDING_FLAGS) |
	                hit(i_paddr, IDX_PRIORITY_A) | hit(i_paddr, IDX_PRIORITY_B);

	// ------------------------------------------------------------
	// apb slave: one wait-free access cycle, ready from a flop
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~mapped;
			if (i_psel & ~i_penable) begin
				o_prdata <= 32'h0000_0000;
				if (hit(i_paddr, IDX_SYSTEM_CONTROL)) o_prdata[7:0] <= sysctl_r;
				if (hit(i_paddr, IDX_SENSE_CONTROL)) o_prdata[7:0] <= sense_r;
				if (hit(i_paddr, IDX_ENABLE_MASK)) o_prdata[7:0] <= enable_r;
				if (hit(i_paddr, IDX_PENDING_FLAGS)) o_prdata[7:0] <= {2'b00, pend_r};
				if (hit(i_paddr, IDX_PRIORITY_A)) o_prdata[7:0] <= prio_a_r;
				if (hit(i_paddr, IDX_PRIORITY_B)) o_prdata[7:0] <= prio_b_r;
			end
		end
	end

	// control registers; hardware standby clears like reset
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sysctl_r <= RST_SYSTEM_CONTROL;
			sense_r  <= RST_ZERO;
			enable_r <= RST_ZERO;
			prio_a_r <= RST_ZERO;
			prio_b_r <= RST_ZERO;
		end else if (i_hw_standby) begin
			sysctl_r <= RST_SYSTEM_CONTROL;
			sense_r  <= RST_ZERO;
			enable_r <= RST_ZERO;
			prio_a_r <= RST_ZERO;
			prio_b_r <= RST_ZERO;
		end else if (wr_cyc) begin
			if (hit(i_paddr, IDX_SYSTEM_CONTROL)) sysctl_r <= i_pwdata[7:0];
			if (hit(i_paddr, IDX_SENSE_CONTROL)) sense_r <= i_pwdata[7:0];
			if (hit(i_paddr, IDX_ENABLE_MASK)) enable_r <= i_pwdata[7:0];
			if (hit(i_paddr, IDX_PRIORITY_A)) prio_a_r <= i_pwdata[7:0];
			if (hit(i_paddr, IDX_PRIORITY_B)) prio_b_r <= i_pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// external request sensing
	// ------------------------------------------------------------
	// sense bit 1 picks falling edge, 0 picks low level
	assign irq_set  = (sense_r[5:0] & irq_prev_n_r & ~i_irq_n) |
	                  (~sense_r[5:0] & ~i_irq_n);
	assign nmi_edge = sysctl_r[BIT_NMI_EDGE] ? (i_nmi & ~nmi_prev_r) :
	                                           (~i_nmi & nmi_prev_r);

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			nmi_prev_r   <= 1'b0;
			irq_prev_n_r <= 6'h3F;
		end else begin
			nmi_prev_r   <= i_nmi;
			irq_prev_n_r <= i_irq_n;
		end
	end

	// a new set beats a clear written in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend_r <= 6'h00;
		end else if (i_hw_standby) begin
			pend_r <= 6'h00;
		end else if (wr_cyc && hit(i_paddr, IDX_PENDING_FLAGS)) begin
			pend_r <= (pend_r & i_pwdata[5:0]) | irq_set;
		end else begin
			pend_r <= pend_r | irq_set;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			nmi_pend_r <= 1'b0;
		end else if (i_hw_standby) begin
			nmi_pend_r <= 1'b0;
		end else if (nmi_edge) begin
			nmi_pend_r <= 1'b1;
		end else if (take_int && nmi_pend_r) begin
			nmi_pend_r <= 1'b0;
		end
	end

	// no interrupt is taken until the first instruction after reset ends (traps are not held off),
	// so the stack pointer can be set up before any push
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			armed_r <= 1'b0;
		end else if (i_hw_standby) begin
			armed_r <= 1'b0;
		end else if (i_insn_done) begin
			armed_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// arbitration
	// ------------------------------------------------------------
	// internal lines are levels held by their peripherals, refresh
	// compare match included
	assign req = {i_int_req, pend_r & enable_r[5:0]};
	assign mask_all = i_ccr_i & (ue | i_ccr_ui);

	genvar g;
	generate
		for (g = 0; g < N_SRC; g++) begin : g_lvl
			assign lvl[g] = prio_of(g, prio_a_r, prio_b_r);
		end
	endgenerate

	// lowest index wins within a level; level 1 beats level 0
	always_comb begin
		found1 = 1'b0;
		found0 = 1'b0;
		sel1   = 0;
		sel0   = 0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (req[i] && lvl[i] && !mask_all) begin
				found1 = 1'b1;
				sel1   = i;
			end
			if (req[i] && !lvl[i] && !i_ccr_i) begin
				found0 = 1'b1;
				sel0   = i;
			end
		end
	end

	assign take_int  = (state_r == ST_IDLE) && armed_r && i_insn_done &&
	                   (nmi_pend_r || found1 || found0);
	assign take_trap = (state_r == ST_IDLE) && i_trap_exec && !take_int;
	assign vec_take  = take_trap ? (VEC_TRAP + {6'h00, i_trap_num}) :
	                   nmi_pend_r ? VEC_NMI :
	                   found1 ? vec_of(sel1) : vec_of(sel0);

	// ------------------------------------------------------------
	// exception sequencer: push, mask, vector fetch
	// ------------------------------------------------------------
	always_comb begin
		case (state_r)
			ST_IDLE:  state_nxt = (take_int || take_trap) ? ST_PUSH : ST_IDLE;
			ST_PUSH:  state_nxt = ST_MASK;
			ST_MASK:  state_nxt = ST_FETCH;
			ST_FETCH: state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r   <= ST_IDLE;
			vec_sel_r <= 8'h00;
			trap_r    <= 1'b0;
			ack_nmi_r <= 1'b0;
			ack_hi_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (take_int || take_trap) begin
				vec_sel_r <= vec_take;
				trap_r    <= take_trap;
				ack_nmi_r <= take_int && nmi_pend_r;
				ack_hi_r  <= take_int && !nmi_pend_r && found1;
			end
		end
	end

	// registered cpu outputs
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_busy      <= 1'b0;
			o_push_req  <= 1'b0;
			o_set_i     <= 1'b0;
			o_set_ui    <= 1'b0;
			o_vec_valid <= 1'b0;
			o_vec_num   <= 8'h00;
			o_vec_addr  <= 16'h0000;
		end else begin
			o_busy      <= state_nxt != ST_IDLE;
			o_push_req  <= state_nxt == ST_PUSH;
			o_set_i     <= state_nxt == ST_MASK;
			// trap: secondary mask too when it acts as mask; interrupt:
			// level 1 and nonmaskable raise it so level 1 stays out too
			o_set_ui    <= (state_nxt == ST_MASK) && !ue &&
			               (trap_r || ack_nmi_r || ack_hi_r);
			o_vec_valid <= state_nxt == ST_FETCH;
			if (state_nxt == ST_FETCH) begin
				o_vec_num  <= vec_sel_r;
				o_vec_addr <= {6'h00, vec_sel_r, 2'b00};
			end
		end
	end

	// word and longword addresses are always even
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_acc_addr <= 24'h00_0000;
		end else begin
			o_acc_addr <= i_acc_wide ? {i_acc_addr[23:1], 1'b0} : i_acc_addr;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	sequence s_take;
		take_int || take_trap;
	endsequence
	sequence s_handle;
		o_push_req ##1 (o_set_i && !o_push_req) ##1 (o_vec_valid && !o_set_i);
	endsequence

	exc_sequence_a: assert property (s_take |=> s_handle)
		else $error("exception sequence out of order");
	nmi_first_a: assert property (take_int && nmi_pend_r |-> ##3 o_vec_num == VEC_NMI)
		else $error("nonmaskable request not served first");
	trap_vec_a: assert property (take_trap |-> ##3 o_vec_num == VEC_TRAP + {6'h00, $past(i_trap_num, 3)})
		else $error("trap vector wrong");
	trap_mask_a: assert property (take_trap |-> ##2 o_set_i && (o_set_ui == !$past(ue, 2)))
		else $error("trap mask bits wrong");
	mask_gate_a: assert property (take_int && !nmi_pend_r |-> !(i_ccr_i && (ue || i_ccr_ui)))
		else $error("request taken through full mask");
	insn_wait_a: assert property (state_r == ST_IDLE && !i_insn_done && !i_trap_exec |=> !o_push_req)
		else $error("exception started mid instruction");
	flag_keep_a: assert property (wr_cyc && hit(i_paddr, IDX_PENDING_FLAGS) && i_pwdata[5:0] == 6'h3F
		|=> pend_r == ($past(pend_r) | $past(irq_set)))
		else $error("writing one changed a pending flag");
	sysctl_rst_a: assert property (i_hw_standby |=> sysctl_r == 8'h0B && enable_r == 8'h00)
		else $error("standby reset values wrong");
	even_addr_a: assert property (i_acc_wide |=> !o_acc_addr[0])
		else $error("wide access address odd");
	vec_addr_a: assert property (o_vec_valid && !trap_r && o_vec_num >= VEC_WDT
		|-> o_vec_num <= VEC_ADC && o_vec_addr == {6'h00, o_vec_num, 2'b00})
		else $error("internal vector out of range");
	apb_ready_a: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
		else $error("apb ready timing wrong");
endmodule // interrupt_priority_controller

// ==== test/cpu_model.sv ====
// cpu core model driving the controller's cpu side
`timescale 1ns/1ns
module cpu_model (
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset_n,
	// bench control
	input  wire logic       i_slow,
	input  wire logic       i_ld,
	input  wire logic       i_ld_i,
	input  wire logic       i_ld_ui,
	input  wire logic       i_trap_go,
	input  wire logic [1:0] i_trap_sel,
	// controller side
	input  wire logic       i_busy,
	input  wire logic       i_set_i,
	input  wire logic       i_set_ui,
	input  wire logic       i_vec_valid,
	output logic            o_ccr_i,
	output logic            o_ccr_ui,
	output logic            o_insn_done,
	output logic            o_trap_exec,
	output logic [1:0]      o_trap_num,
	output logic            o_last_ui,
	output logic [7:0]      o_vec_cnt
);
	logic [1:0] phase_r;

	// ------------------------------------------------------------
	// instruction flow and mask bits
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase_r     <= 2'h0;
			o_ccr_i     <= 1'b1;
			o_ccr_ui    <= 1'b0;
			o_insn_done <= 1'b0;
			o_trap_exec <= 1'b0;
			o_trap_num  <= 2'h0;
			o_last_ui   <= 1'b0;
			o_vec_cnt   <= 8'h00;
		end else begin
			phase_r     <= phase_r + 2'h1;
			// slow mode: long instructions end only every fourth cycle
			o_insn_done <= !i_busy && (!i_slow || phase_r == 2'h3);
			// a trap during exception handling would be lost, so hold it off
			o_trap_exec <= i_trap_go && !i_busy;
			o_trap_num  <= i_trap_sel;
			if (i_ld) begin
				o_ccr_i  <= i_ld_i;
				o_ccr_ui <= i_ld_ui;
			end else begin
				if (i_set_i)
					o_ccr_i <= 1'b1;
				if (i_set_ui)
					o_ccr_ui <= 1'b1;
			end
			if (i_set_i)
				o_last_ui <= i_set_ui;
			if (i_vec_valid)
				o_vec_cnt <= o_vec_cnt + 8'h01;
		end
	end
endmodule // cpu_model

// ==== test/interrupt_priority_controller_tb.sv ====
// self-checking bench of the interrupt priority controller
`timescale 1ns/1ns
module interrupt_priority_controller_tb
	import irqc_pkg::*;
;
	logic              clk, rst_n, hw_sb, psel, penable, pwrite, pready, pslverr, nmi;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd_v;
	logic [N_EXT-1:0]  irq_n;
	logic [N_INT-1:0]  int_req;
	logic [23:0]       acc_addr, acc_o;
	logic              acc_wide, er_v, slow, ld, ld_i, ld_ui, trap_go, last_ui, push_req;
	logic [1:0]        trap_sel, trap_num;
	logic              ccr_i, ccr_ui, insn_done, trap_exec, busy, set_i, set_ui, vec_valid;
	logic [7:0]        vec_num, vec_cnt;
	logic [15:0]       vec_addr;
	int                err_count, checks, cyc, push_cnt;
	logic [15:0]       idx_tab [6] = '{IDX_SYSTEM_CONTROL, IDX_SENSE_CONTROL, IDX_ENABLE_MASK,
		IDX_PENDING_FLAGS, IDX_PRIORITY_A, IDX_PRIORITY_B};

	always #25 clk = ~clk;

	interrupt_priority_controller i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_hw_standby(hw_sb),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_nmi(nmi), .i_irq_n(irq_n), .i_int_req(int_req), .i_ccr_i(ccr_i), .i_ccr_ui(ccr_ui),
		.i_insn_done(insn_done), .i_trap_exec(trap_exec), .i_trap_num(trap_num),
		.i_acc_addr(acc_addr), .i_acc_wide(acc_wide), .o_busy(busy), .o_push_req(push_req),
		.o_set_i(set_i), .o_set_ui(set_ui), .o_vec_valid(vec_valid), .o_vec_num(vec_num),
		.o_vec_addr(vec_addr), .o_acc_addr(acc_o));

	cpu_model i_cpu (.i_clk_sys(clk), .i_reset_n(rst_n), .i_slow(slow), .i_ld(ld),
		.i_ld_i(ld_i), .i_ld_ui(ld_ui), .i_trap_go(trap_go), .i_trap_sel(trap_sel),
		.i_busy(busy), .i_set_i(set_i), .i_set_ui(set_ui), .i_vec_valid(vec_valid),
		.o_ccr_i(ccr_i), .o_ccr_ui(ccr_ui), .o_insn_done(insn_done), .o_trap_exec(trap_exec),
		.o_trap_num(trap_num), .o_last_ui(last_ui), .o_vec_cnt(vec_cnt));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// wait states are allowed: the request is held until pready is sampled high
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		// if pready never comes high, only the bench's cycle ceiling ends this wait
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd_v    = prdata;
		er_v    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk("register read", {24'h000000, exp}, rd_v);
		chk("read error", 32'h0, 32'(er_v));
	endtask

	task automatic wait_vec(input logic [7:0] num);
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			#1;
			if (vec_valid === 1'b1)
				break;
		end
		chk("vector seen", 32'h1, 32'(vec_valid));
		chk("vector number", 32'(num), 32'(vec_num));
		chk("vector address", {22'h0, num, 2'b00}, 32'(vec_addr));
		chk("busy with vector", 32'h1, 32'(busy));
		// back onto the edge so callers drive stimulus at a rising edge
		@(posedge clk);
	endtask

	task automatic no_vec();
		logic [7:0] c;
		// the model counts a vector one edge after its pulse
		@(posedge clk);
		c = vec_cnt;
		repeat (16) @(posedge clk);
		chk("no vector", 32'(c), 32'(vec_cnt));
	endtask

	task automatic condition_code_register(input logic i, input logic ui);
		@(posedge clk);
		ld    <= 1'b1;
		ld_i  <= i;
		ld_ui <= ui;
		@(posedge clk);
		ld    <= 1'b0;
	endtask

	task automatic trap(input logic [1:0] t);
		@(posedge clk);
		trap_sel <= t;
		trap_go  <= 1'b1;
		@(posedge clk);
		trap_go  <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// hang guard and main sequence
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (push_req === 1'b1)
			push_cnt++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		{clk, hw_sb, psel, penable, pwrite, acc_wide, slow, ld, ld_i, ld_ui, trap_go} = '0;
		{paddr, pwdata, int_req, acc_addr, trap_sel} = '0;
		{err_count, checks, cyc, push_cnt} = '0;
		nmi   = 1'b1;
		irq_n = '1;
		rst_n = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd_chk(idx_tab[i], (i == 0) ? RST_SYSTEM_CONTROL : RST_ZERO);
		apb(1'b0, 16'hFFF3, 8'h00);
		chk("unmapped error", 32'h1, 32'(er_v));
		for (int i = 1; i < 6; i++) begin
			if (i != 3) begin
				apb(1'b1, idx_tab[i], 8'hA5);
				rd_chk(idx_tab[i], 8'hA5);
				apb(1'b1, idx_tab[i], 8'h00);
			end
		end
		$display("test registers done");
		condition_code_register(1'b1, 1'b1);
		for (int t = 0; t < 4; t++) begin
			trap(2'(t));
			wait_vec(VEC_TRAP + 8'(t));
			chk("trap secondary mask", 32'h0, 32'(last_ui));
		end
		apb(1'b1, IDX_SYSTEM_CONTROL, 8'h03);
		trap(2'h2);
		wait_vec(VEC_TRAP + 8'h02);
		chk("trap secondary mask", 32'h1, 32'(last_ui));
		apb(1'b1, IDX_SYSTEM_CONTROL, 8'h0B);
		$display("test traps done");
		@(posedge clk);
		nmi <= 1'b0;
		wait_vec(VEC_NMI);
		@(posedge clk);
		nmi <= 1'b1;
		no_vec();
		apb(1'b1, IDX_SYSTEM_CONTROL, 8'h0F);
		nmi <= 1'b0;
		no_vec();
		nmi <= 1'b1;
		wait_vec(VEC_NMI);
		apb(1'b1, IDX_SYSTEM_CONTROL, 8'h0B);
		$display("test nonmaskable done");
		apb(1'b1, IDX_SENSE_CONTROL, 8'h01);
		apb(1'b1, IDX_ENABLE_MASK, 8'h03);
		@(posedge clk);
		irq_n[0] <= 1'b0;
		@(posedge clk);
		irq_n[0] <= 1'b1;
		rd_chk(IDX_PENDING_FLAGS, 8'h01);
		condition_code_register(1'b0, 1'b0);
		wait_vec(8'(VEC_IRQ0));
		apb(1'b1, IDX_PENDING_FLAGS, 8'hFF);
		rd_chk(IDX_PENDING_FLAGS, 8'h01);
		apb(1'b1, IDX_PENDING_FLAGS, 8'h00);
		rd_chk(IDX_PENDING_FLAGS, 8'h00);
		irq_n[1] <= 1'b0;
		condition_code_register(1'b0, 1'b0);
		wait_vec(8'(VEC_IRQ0 + 1));
		irq_n[1] <= 1'b1;
		apb(1'b1, IDX_PENDING_FLAGS, 8'h00);
		rd_chk(IDX_PENDING_FLAGS, 8'h00);
		$display("test external pins done");
		apb(1'b1, IDX_SYSTEM_CONTROL, 8'h03);
		apb(1'b1, IDX_PRIORITY_B, 8'h02);
		slow       <= 1'b1;
		int_req[0] <= 1'b1;
		int_req[N_INT-1] <= 1'b1;
		condition_code_register(1'b1, 1'b0);
		wait_vec(8'(VEC_ADC));
		chk("level one secondary mask", 32'h1, 32'(last_ui));
		int_req[N_INT-1] <= 1'b0;
		no_vec();
		condition_code_register(1'b0, 1'b0);
		wait_vec(8'(VEC_WDT));
		int_req[0] <= 1'b0;
		slow       <= 1'b0;
		apb(1'b1, IDX_PRIORITY_A, 8'h08);
		int_req[1] <= 1'b1;
		wait_vec(8'(VEC_WDT + 1));
		int_req[1] <= 1'b0;
		$display("test priority done");
		acc_addr <= 24'h000123;
		acc_wide <= 1'b1;
		@(posedge clk);
		#1;
		@(posedge clk);
		#1;
		chk("wide access address", 32'h00000122, 32'(acc_o));
		@(posedge clk);
		acc_wide <= 1'b0;
		@(posedge clk);
		#1;
		chk("byte access address", 32'h00000123, 32'(acc_o));
		apb(1'b1, IDX_PRIORITY_A, 8'hA5);
		@(posedge clk);
		hw_sb <= 1'b1;
		@(posedge clk);
		hw_sb <= 1'b0;
		rd_chk(IDX_PRIORITY_A, 8'h00);
		rd_chk(IDX_SYSTEM_CONTROL, RST_SYSTEM_CONTROL);
		$display("test address and standby done");
		chk("push count", 32'h0000000C, 32'(push_cnt));
		chk("vector count", 32'h0000000C, 32'(vec_cnt));
		summarize();
	end
endmodule // interrupt_priority_controller_tb
